// ==== rgbdim_cmd.sv ====
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Ramp duration equals step time times steps.
// - Ramp moves level stepwise toward the end.
// - End from target register; end level kept at or below 30.
// - Current write applies level at acknowledge.
// - Ramp begins at acknowledge of trigger byte.
// - Every register loads by its own transfer.
// - Select 000 shuts down, low bits ignored.
// - Select 001 loads common current level.
// - Selects 010, 011, 100 load channel duties.
// - Selects 101, 110 load rising/falling targets.
// - Select 111 stores step time, starts ramp; time zero jumps to end.
// - Step count is absolute position difference.
// - Five-bit level allows long ramps.
// - Step time counts in 8 ms units.
// - Five-bit duty gives 32 modulation levels.
// - Duty zero keeps channel fully off.
// - Duty all ones keeps channel fully on.
// - Modulator changes only ratio, 2.1 kHz frame.
// - Three modulators independent, updatable anytime.
// - Write-only receiver at address 0111000.
// - Level zero forces zero current.
// - Direct level serves all channels, no ramp.
module rgbdim_cmd #(
   parameter int unsigned STEP_UNIT_CYC = rgbdim_pkg::STEP_UNIT_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic LINK_CLK_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   output logic [2:0] LED_ON_O,
   output logic [4:0] LED_LEVEL_O,
   output logic RAMP_BUSY_O,
   output logic SHUTDOWN_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: serial receiver on the link clock.

   rgbdim_pkg::rgbdim_link_t lk;
   rgbdim_pkg::rgbdim_link_t next_lk;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_comb begin
      next_lk = lk;
      next_lk.rst_s1 = SYS_RST_I;
      next_lk.rst_s2 = lk.rst_s1;
      next_lk.scl_s1 = SCL_I;
      next_lk.scl_s2 = lk.scl_s1;
      next_lk.scl_d = lk.scl_s2;
      next_lk.sda_s1 = SDA_I;
      next_lk.sda_s2 = lk.sda_s1;
      next_lk.sda_d = lk.sda_s2;
      scl_rise = lk.scl_s2 & ~lk.scl_d;
      scl_fall = ~lk.scl_s2 & lk.scl_d;
      bus_start = lk.scl_s2 & lk.scl_d & lk.sda_d & ~lk.sda_s2;
      bus_stop = lk.scl_s2 & lk.scl_d & ~lk.sda_d & lk.sda_s2;
      if (bus_start) begin
         next_lk.state = rgbdim_pkg::L_ADDR;
         next_lk.cnt = 4'h0;
         next_lk.sda_oe = 1'b0;
      end else if (bus_stop) begin
         next_lk.state = rgbdim_pkg::L_IDLE;
         next_lk.sda_oe = 1'b0;
      end else begin
         case (lk.state)
            rgbdim_pkg::L_ADDR, rgbdim_pkg::L_DATA: begin
               if (scl_rise) begin
                  next_lk.sh = {lk.sh[6:0], lk.sda_s2};
                  next_lk.cnt = lk.cnt + 4'h1;
               end else if (scl_fall && lk.cnt == rgbdim_pkg::BITS_PER_BYTE) begin
                  next_lk.cnt = 4'h0;
                  if (lk.state == rgbdim_pkg::L_DATA) begin
                     next_lk.data = lk.sh;
                     next_lk.state = rgbdim_pkg::L_DACK;
                     next_lk.sda_oe = 1'b1;
                  end else if (lk.sh[7:1] == rgbdim_pkg::DEV_ADDR && !lk.sh[0]) begin
                     next_lk.state = rgbdim_pkg::L_AACK;
                     next_lk.sda_oe = 1'b1;
                  end else begin
                     next_lk.state = rgbdim_pkg::L_SKIP;
                  end
               end
            end
            rgbdim_pkg::L_AACK, rgbdim_pkg::L_DACK: begin
               if (scl_rise) begin
                  next_lk.cnt = 4'h1;
                  // The data byte is handed over at its acknowledge clock.
                  if (lk.state == rgbdim_pkg::L_DACK) begin
                     next_lk.tog = ~lk.tog;
                  end
               end else if (scl_fall && lk.cnt == 4'h1) begin
                  next_lk.cnt = 4'h0;
                  next_lk.sda_oe = 1'b0;
                  // One data byte per frame; further bytes are not acknowledged.
                  next_lk.state = (lk.state == rgbdim_pkg::L_AACK) ? rgbdim_pkg::L_DATA : rgbdim_pkg::L_SKIP;
               end
            end
            rgbdim_pkg::L_IDLE, rgbdim_pkg::L_SKIP: begin
               next_lk.sda_oe = 1'b0;
            end
            default: begin
               next_lk.state = rgbdim_pkg::L_IDLE;
               next_lk.sda_oe = 1'b0;
            end
         endcase
      end
      if (lk.rst_s2) begin
         next_lk.state = rgbdim_pkg::L_IDLE;
         next_lk.cnt = 4'h0;
         next_lk.sh = 8'h00;
         next_lk.data = 8'h00;
         next_lk.tog = 1'b0;
         next_lk.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      lk <= next_lk;
   end

   // Open-drain: only ever pulls low.
   assign SDA_O = 1'b0;
   assign SDA_OE_O = lk.sda_oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Core domain: command decode, ramp engine, modulators.

   rgbdim_pkg::rgbdim_core_t st;
   rgbdim_pkg::rgbdim_core_t next_st;
   logic cmd_valid;
   logic [2:0] cmd_fn;
   logic [4:0] cmd_val;
   logic [4:0] new_end;
   logic [4:0] new_steps;
   logic unit_done;
   logic step_now;
   logic [2:0] pwm_hit;

   // The byte register is stable for many link clocks before the toggle arrives here.
   assign cmd_valid = st.tog_s3 != st.tog_s2;
   assign cmd_fn = lk.data[7:rgbdim_pkg::FN_POS];
   assign cmd_val = lk.data[rgbdim_pkg::VAL_W-1:0];

   // Code 31 gives the same current as 30, so the end is held at the maximum code.
   always_comb begin
      // Direction comes from the registered flag, so the end level never loops back through next_st.
      new_end = st.dir_down ? st.fall_tgt : st.rise_tgt;
      if (new_end > rgbdim_pkg::MAXIMUM_LEVEL_CODE) begin
         new_end = rgbdim_pkg::MAXIMUM_LEVEL_CODE;
      end
      new_steps = (st.level > new_end) ? st.level - new_end : new_end - st.level;
   end

   localparam logic [rgbdim_pkg::UNIT_CNT_W-1:0] UNIT_CNT_LAST = rgbdim_pkg::UNIT_CNT_W'(STEP_UNIT_CYC - 1);
   localparam logic [rgbdim_pkg::PWM_DIV_W-1:0] PWM_DIV_LAST =
      rgbdim_pkg::PWM_DIV_W'(rgbdim_pkg::PWM_SLOT_CYC - 1);

   assign unit_done = st.unit_cnt == UNIT_CNT_LAST;
   assign step_now = st.ramping && unit_done && (st.unit_num + 5'h01 >= st.step_time);

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_chan
         assign pwm_hit[ch] = (st.duty[ch] == rgbdim_pkg::DUTY_FULL) || (st.pwm_cnt < st.duty[ch]);
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.tog_s1 = lk.tog;
      next_st.tog_s2 = st.tog_s1;
      next_st.tog_s3 = st.tog_s2;

      // Free-running slot counter, shared by the three channels.
      if (st.pwm_div == PWM_DIV_LAST) begin
         next_st.pwm_div = '0;
         next_st.pwm_cnt = st.pwm_cnt + 5'h01;
      end else begin
         next_st.pwm_div = st.pwm_div + 1'b1;
      end

      // Step timer: per-step wait is the time code in units, so no divider is needed.
      if (st.ramping) begin
         next_st.unit_cnt = unit_done ? '0 : st.unit_cnt + 1'b1;
         if (unit_done) begin
            next_st.unit_num = step_now ? 5'h00 : st.unit_num + 5'h01;
         end
         if (step_now) begin
            next_st.level = (st.level < st.ramp_end_level) ? st.level + 5'h01 : st.level - 5'h01;
            next_st.steps_left = st.steps_left - 5'h01;
            if (st.steps_left == 5'h01) begin
               next_st.ramping = 1'b0;
            end
         end
      end

      if (cmd_valid) begin
         // Any function other than shutdown wakes the device.
         next_st.shutdown = 1'b0;
         case (cmd_fn)
            rgbdim_pkg::FN_SHUTDOWN: begin
               next_st.shutdown = 1'b1;
               next_st.ramping = 1'b0;
            end
            rgbdim_pkg::FN_CURRENT: begin
               next_st.level = cmd_val;
               next_st.ramping = 1'b0;
            end
            rgbdim_pkg::FN_DUTY1: begin
               next_st.duty[0] = cmd_val;
            end
            rgbdim_pkg::FN_DUTY2: begin
               next_st.duty[1] = cmd_val;
            end
            rgbdim_pkg::FN_DUTY3: begin
               next_st.duty[2] = cmd_val;
            end
            rgbdim_pkg::FN_RISE_TGT: begin
               next_st.rise_tgt = cmd_val;
               next_st.dir_down = 1'b0;
            end
            rgbdim_pkg::FN_FALL_TGT: begin
               next_st.fall_tgt = cmd_val;
               next_st.dir_down = 1'b1;
            end
            rgbdim_pkg::FN_TIME_RUN: begin
               // A run during a ramp restarts from the present level.
               next_st.step_time = cmd_val;
               next_st.ramp_end_level = new_end;
               next_st.steps_left = new_steps;
               next_st.unit_cnt = '0;
               next_st.unit_num = 5'h00;
               if (new_steps == 5'h00) begin
                  next_st.ramping = 1'b0;
               end else if (cmd_val == 5'h00) begin
                  next_st.level = new_end;
                  next_st.ramping = 1'b0;
               end else begin
                  next_st.ramping = 1'b1;
               end
            end
            default: begin
               next_st.shutdown = st.shutdown;
            end
         endcase
      end

      next_st.led_level = st.shutdown ? rgbdim_pkg::LEVEL_ZERO : st.level;
      next_st.led_on = (st.shutdown || st.level == rgbdim_pkg::LEVEL_ZERO) ? 3'h0 : pwm_hit;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         st <= '0;
         st.level <= rgbdim_pkg::RST_LEVEL;
         st.duty <= {3{rgbdim_pkg::RST_DUTY}};
         st.rise_tgt <= rgbdim_pkg::RST_TARGET;
         st.fall_tgt <= rgbdim_pkg::RST_TARGET;
         st.step_time <= rgbdim_pkg::RST_TIME;
         st.shutdown <= rgbdim_pkg::RST_SHUTDOWN;
      end else begin
         st <= next_st;
      end
   end

   assign LED_ON_O = st.led_on;
   assign LED_LEVEL_O = st.led_level;
   assign RAMP_BUSY_O = st.ramping;
   assign SHUTDOWN_O = st.shutdown;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_SHUTDOWN_DARK: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      st.shutdown |=> (LED_ON_O == 3'h0 && LED_LEVEL_O == 5'h00))
      else $error("outputs not dark in shutdown");

   AST_DUTY_ZERO_OFF: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (st.duty[0] == 5'h00) |=> !LED_ON_O[0])
      else $error("channel on with zero duty");

   AST_DUTY_FULL_ON: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (st.duty[1] == 5'h1F && !st.shutdown && st.level != 5'h00) |=> LED_ON_O[1])
      else $error("full duty channel not on");

   AST_LEVEL_DIRECT: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (cmd_valid && cmd_fn == 3'h1) |=> (st.level == $past(cmd_val) && !st.ramping) ##1
      (LED_LEVEL_O == $past(st.level)))
      else $error("direct level not applied");

   AST_END_BOUNDED: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      st.ramping |-> (st.ramp_end_level <= 5'h1E && st.steps_left != 5'h00))
      else $error("ramp end or count out of range");

   AST_SINGLE_STEP: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      ($past(st.ramping) && !$past(cmd_valid) && st.level != $past(st.level)) |->
      (st.level == $past(st.level) + 5'h01 || st.level == $past(st.level) - 5'h01))
      else $error("ramp jumped more than one step");

   AST_RAMP_COUNT: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (cmd_valid && cmd_fn == 3'h7 && cmd_val != 5'h00 && new_steps != 5'h00) |=>
      (st.ramping && st.steps_left == $past(new_steps) && st.ramp_end_level == $past(new_end)))
      else $error("ramp not started with computed count");

   AST_STEP_PACED: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      ($past(st.ramping) && !$past(cmd_valid) && st.level != $past(st.level)) |->
      ($past(st.unit_cnt) == UNIT_CNT_LAST && $past(st.unit_num) + 5'h01 >= $past(st.step_time)))
      else $error("ramp step off the time base");

   AST_ACK_ONLY_MATCH: assert property (
      @(posedge LINK_CLK_I) disable iff (lk.rst_s2)
      (lk.state == rgbdim_pkg::L_ADDR && next_lk.state == rgbdim_pkg::L_AACK) |->
      (lk.sh[7:1] == 7'h38 && !lk.sh[0]) ##1 lk.sda_oe)
      else $error("acknowledged a foreign address");

   AST_ACK_WINDOW: assert property (
      @(posedge LINK_CLK_I) disable iff (lk.rst_s2)
      lk.sda_oe |-> (lk.state == rgbdim_pkg::L_AACK || lk.state == rgbdim_pkg::L_DACK))
      else $error("data line pulled outside an acknowledge");

   AST_RAMP_LANDS: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      ($past(st.ramping) && !st.ramping && !$past(cmd_valid)) |->
      (st.level == $past(st.ramp_end_level)))
      else $error("ramp ended off its end level");

   AST_SHUTDOWN_HALTS: assert property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      (cmd_valid && cmd_fn == 3'h0) |=>
      (st.shutdown && !st.ramping))
      else $error("shutdown did not stop the device");

   COV_LEVEL_DIRECT: cover property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      cmd_valid && cmd_fn == 3'h1);

   COV_RAMP_DONE: cover property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      st.ramping ##1 !st.ramping);

   COV_SHUTDOWN: cover property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      cmd_valid && cmd_fn == 3'h0);

   COV_RAMP_RESTART: cover property (
      @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
      st.ramping && cmd_valid && cmd_fn == 3'h7);

   COV_DATA_ACK: cover property (
      @(posedge LINK_CLK_I) disable iff (lk.rst_s2)
      lk.state == rgbdim_pkg::L_DACK && lk.sda_oe);

endmodule
`default_nettype wire

// ==== rgbdim_pkg.sv ====
package rgbdim_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;

   // Ramp time base: one unit of the step time field.
   localparam int unsigned STEP_UNIT_MS = 8;
   localparam int unsigned STEP_UNIT_CYC = CLK_HZ / 1000 * STEP_UNIT_MS;
   localparam int unsigned UNIT_CNT_W = 18;

   // Modulation frame rate; each frame holds 32 slots.
   localparam int unsigned PWM_FREQ_HZ = 2100;
   localparam int unsigned PWM_SLOTS = 32;
   localparam int unsigned PWM_SLOT_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_SLOTS);
   localparam int unsigned PWM_DIV_W = 9;

   // Seven bit receiver address on the serial link.
   localparam logic [6:0] DEV_ADDR = 7'h38;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Function select codes, top three bits of the data byte.
   localparam logic [2:0] FN_SHUTDOWN = 3'h0;
   localparam logic [2:0] FN_CURRENT = 3'h1;
   localparam logic [2:0] FN_DUTY1 = 3'h2;
   localparam logic [2:0] FN_DUTY2 = 3'h3;
   localparam logic [2:0] FN_DUTY3 = 3'h4;
   localparam logic [2:0] FN_RISE_TGT = 3'h5;
   localparam logic [2:0] FN_FALL_TGT = 3'h6;
   localparam logic [2:0] FN_TIME_RUN = 3'h7;
   localparam int unsigned FN_POS = 5;
   localparam int unsigned VAL_W = 5;

   localparam logic [4:0] MAXIMUM_LEVEL_CODE = 5'h1E;
   localparam logic [4:0] DUTY_FULL = 5'h1F;
   localparam logic [4:0] LEVEL_ZERO = 5'h00;

   // Values after reset.
   localparam logic [4:0] RST_LEVEL = 5'h00;
   localparam logic [4:0] RST_DUTY = 5'h00;
   localparam logic [4:0] RST_TARGET = 5'h00;
   localparam logic [4:0] RST_TIME = 5'h00;
   localparam logic RST_SHUTDOWN = 1'b0;

   typedef enum logic [2:0] {
      L_IDLE,
      L_ADDR,
      L_AACK,
      L_DATA,
      L_DACK,
      L_SKIP
   } rgbdim_link_state_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      rgbdim_link_state_t state;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] data;
      logic tog;
      logic sda_oe;
   } rgbdim_link_t;

   typedef struct packed {
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      logic [4:0] level;
      logic [2:0][4:0] duty;
      logic [4:0] rise_tgt;
      logic [4:0] fall_tgt;
      logic [4:0] step_time;
      logic dir_down;
      logic shutdown;
      logic ramping;
      logic [4:0] ramp_end_level;
      logic [4:0] steps_left;
      logic [UNIT_CNT_W-1:0] unit_cnt;
      logic [4:0] unit_num;
      logic [PWM_DIV_W-1:0] pwm_div;
      logic [4:0] pwm_cnt;
      logic [2:0] led_on;
      logic [4:0] led_level;
   } rgbdim_core_t;

endpackage

// ==== rgbdim_host.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module rgbdim_host #(
   parameter int HALF = 5
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // The data line is open drain: the host only pulls low and leaves the high level to the pull-up.
   initial begin
      scl_o = 1'h1;
      sda_low_o = 1'h0;
   end

   task automatic gap();
      repeat (HALF) @(negedge clk_i);
   endtask

   // Data moves two core cycles after each clock fall, so it never changes while the clock is seen high.
   task automatic pulse();
      gap();
      scl_o = 1'h1;
      gap();
      scl_o = 1'h0;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low_o = ~b[i];
         pulse();
      end
      sda_low_o = 1'h0;
      gap();
      scl_o = 1'h1;
      gap();
      ack = ~sda_i;
      scl_o = 1'h0;
      repeat (2) @(negedge clk_i);
   endtask

   // One address byte and one data byte per frame, so each register load is a frame of its own.
   task automatic frame(input logic [7:0] addr, input logic [7:0] data, output logic ack_a,
                        output logic ack_d);
      sda_low_o = 1'h1;
      gap();
      scl_o = 1'h0;
      repeat (2) @(negedge clk_i);
      put_byte(addr, ack_a);
      put_byte(data, ack_d);
      sda_low_o = 1'h1;
      gap();
      scl_o = 1'h1;
      gap();
      sda_low_o = 1'h0;
      gap();
   endtask
endmodule
`default_nettype wire

// ==== rgbdim_cmd_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module rgbdim_cmd_tb_top;
   localparam int SU = 20;
   localparam int SLOT = rgbdim_pkg::PWM_SLOT_CYC;
   localparam int LIMIT = 60000;
   logic clk = 1'h0;
   logic lclk = 1'h0;
   logic rst = 1'h1;
   logic scl;
   logic host_low;
   logic sda_oe;
   logic sda_out;
   logic [2:0] led_on;
   logic [4:0] level;
   logic busy;
   logic shut;
   wire logic sda;
   int n_mismatch = 0;
   int checks_done = 0;
   int busy_cyc = 0;
   int bad_step = 0;
   int max_lvl = 0;
   int cyc = 0;
   logic [4:0] prev_lvl = 5'h00;

   // The data wire has a pull-up, so a released line reads high.
   assign sda = (host_low === 1'h1 || (sda_oe === 1'h1 && sda_out === 1'h0)) ? 1'h0 : 1'h1;

   initial begin
      forever #20 clk = ~clk;
   end
   initial begin
      #3;
      forever begin
         #7 lclk = 1'h1;
         #8 lclk = 1'h0;
      end
   end

   rgbdim_cmd #(.STEP_UNIT_CYC(SU)) i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK_CLK_I(lclk),
      .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out), .SDA_OE_O(sda_oe), .LED_ON_O(led_on),
      .LED_LEVEL_O(level), .RAMP_BUSY_O(busy), .SHUTDOWN_O(shut));
   rgbdim_host #(.HALF(5)) i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prev_lvl <= level;
      if (busy === 1'h1) begin
         busy_cyc <= busy_cyc + 1;
         if (level !== prev_lvl && level !== prev_lvl + 5'h01 && level !== prev_lvl - 5'h01) begin
            bad_step <= bad_step + 1;
         end
      end
      if (int'(level) > max_lvl) begin
         max_lvl <= int'(level);
      end
      if (cyc == LIMIT) begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] d, input logic exp_ack);
      logic aa;
      logic ad;
      i_host.frame(addr, d, aa, ad);
      chk({aa, ad}, {exp_ack, exp_ack});
      repeat (4) @(negedge clk);
   endtask

   // A ramp of n steps at time code t must last n*t units, with one cycle of slack for the handover.
   task automatic ramp_end(input int n, input int t, input logic [4:0] lvl);
      for (int i = 0; i < 5000 && busy !== 1'h0; i++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk(32'(busy_cyc >= n * t * SU && busy_cyc <= n * t * SU + 1), 32'h1);
      chk(level, lvl);
      chk(bad_step, 32'h0);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int on_cnt [3];
      repeat (5) @(negedge clk);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      chk({level, led_on, busy, shut}, 32'h0);
      $display("test reset done");
      wr(8'h71, 8'h3F, 1'h0);
      wr(8'h72, 8'h3F, 1'h0);
      chk(level, 32'h0);
      $display("test address done");
      wr(8'h70, 8'h25, 1'h1);
      chk(level, 32'h5);
      chk(busy, 32'h0);
      $display("test level done");
      wr(8'h70, 8'h40, 1'h1);
      wr(8'h70, 8'h7F, 1'h1);
      wr(8'h70, 8'h90, 1'h1);
      on_cnt = '{0, 0, 0};
      repeat (32 * SLOT) begin
         @(negedge clk);
         for (int k = 0; k < 3; k++) on_cnt[k] += int'(led_on[k]);
      end
      chk(on_cnt[0], 32'h0);
      chk(on_cnt[1], 32 * SLOT);
      chk(on_cnt[2], 16 * SLOT);
      chk(level, 32'h5);
      wr(8'h70, 8'h20, 1'h1);
      chk(led_on, 32'h0);
      $display("test modulation done");
      wr(8'h70, 8'h25, 1'h1);
      wr(8'h70, 8'h1F, 1'h1);
      chk({shut, level, led_on}, 32'h100);
      wr(8'h70, 8'h25, 1'h1);
      chk({shut, level}, 32'h5);
      $display("test shutdown done");
      wr(8'h70, 8'hAF, 1'h1);
      busy_cyc = 0;
      wr(8'h70, 8'hE2, 1'h1);
      chk(busy, 32'h1);
      ramp_end(10, 2, 5'h0F);
      wr(8'h70, 8'hC1, 1'h1);
      busy_cyc = 0;
      wr(8'h70, 8'hE4, 1'h1);
      ramp_end(14, 4, 5'h01);
      $display("test ramp done");
      wr(8'h70, 8'hBE, 1'h1);
      wr(8'h70, 8'hE3, 1'h1);
      wr(8'h70, 8'hD4, 1'h1);
      max_lvl = 0;
      wr(8'h70, 8'hE1, 1'h1);
      for (int i = 0; i < 5000 && busy !== 1'h0; i++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk(level, 32'h14);
      chk(32'(max_lvl <= 20), 32'h1);
      wr(8'h70, 8'hBF, 1'h1);
      busy_cyc = 0;
      wr(8'h70, 8'hE1, 1'h1);
      ramp_end(10, 1, 5'h1E);
      wr(8'h70, 8'hC3, 1'h1);
      wr(8'h70, 8'hE0, 1'h1);
      chk({busy, level}, 32'h03);
      wr(8'h70, 8'hE5, 1'h1);
      chk({busy, level}, 32'h03);
      $display("test restart and clamp done");
      finish_test();
   end
endmodule
`default_nettype wire
